// ---- hw/cpu_register_set.sv ----
// cpu register set: general registers, fetch pointer, control registers
`timescale 1ns/1ps
module cpu_register_set #(
    parameter int ADDR_W = crs_pkg::CRS_ADDR_W
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire crs_pkg::crs_gpr_req_type GPR_WR,
    input wire logic [2:0] GPR_RD_IDX,
    input wire crs_pkg::crs_part_type GPR_RD_PART,
    output logic [31:0] GPR_RD_DATA,
    input wire logic SP_STEP_EN,
    input wire logic SP_STEP_DOWN,
    input wire logic SP_STEP_LONG,
    output logic [31:0] STACK_PTR,
    input wire logic PC_LOAD_EN,
    input wire logic [ADDR_W-1:0] PC_LOAD_VAL,
    input wire logic PC_ADV,
    output logic [ADDR_W-1:0] NEXT_FETCH_PTR,
    output logic [ADDR_W-1:0] FETCH_ADDR,
    input wire crs_pkg::crs_ctl_req_type CTL_REQ,
    output logic [7:0] CTL_RD_DATA,
    output logic [7:0] EXTENDED_CTL_REG,
    output logic [7:0] COND_CODE_REG,
    input wire crs_pkg::crs_alu_req_type ALU_REQ,
    input wire crs_pkg::crs_flag_req_type FLAG_WR,
    input wire logic EXC_START,
    input wire logic INSTR_DONE,
    output logic TRACE_REQ,
    input wire logic NMI_REQ,
    input wire logic IRQ_REQ,
    input wire logic [2:0] IRQ_LEVEL,
    output logic NMI_ACCEPT,
    output logic IRQ_ACCEPT,
    output logic INT_HOLD_OFF,
    input wire logic [3:0] BRANCH_COND,
    output logic BRANCH_TAKEN,
    input wire logic MAC_CLR,
    input wire logic MAC_WR_EN,
    input wire logic [63:0] MAC_WR_VAL,
    output logic [63:0] MULT_ACCUM_REG
);
    import crs_pkg::*;

    // carry out of bit pos when adding the low pos+1 bits
    function automatic logic carry_at(input logic [31:0] a, input logic [31:0] b,
                                      input logic ci, input int pos);
        logic [32:0] m;
        logic [32:0] s;
        m = (33'h000000002 << pos) - 33'h000000001;
        s = ({1'b0, a} & m) + ({1'b0, b} & m) + {32'h00000000, ci};
        carry_at = s[pos+1];
    endfunction

    // branch condition decode; codes 0/1 always/never, others pairwise
    function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] r);
        logic n, z, v, c;
        n = r[CRS_N_BIT];
        z = r[CRS_Z_BIT];
        v = r[CRS_V_BIT];
        c = r[CRS_C_BIT];
        case (cc)
            4'h0: cond_true = 1'b1;
            4'h1: cond_true = 1'b0;
            4'h2: cond_true = !(c | z);
            4'h3: cond_true = c | z;
            4'h4: cond_true = !c;
            4'h5: cond_true = c;
            4'h6: cond_true = !z;
            4'h7: cond_true = z;
            4'h8: cond_true = !v;
            4'h9: cond_true = v;
            4'ha: cond_true = !n;
            4'hb: cond_true = n;
            4'hc: cond_true = !(n ^ v);
            4'hd: cond_true = n ^ v;
            4'he: cond_true = !(z | (n ^ v));
            default: cond_true = z | (n ^ v);
        endcase
    endfunction

    logic [31:0] sp_r;
    logic [31:0] sp_step_val;
    logic [31:0] sp_lane_mask;
    logic [3:0] sp_lanes;
    crs_gpr_req_type mem_wr;
    logic [ADDR_W-1:0] pc_r;
    logic [7:0] exr_r;
    logic [7:0] exr_nxt;
    logic [7:0] ccr_r;
    logic [7:0] ccr_nxt;
    logic [7:0] ctl_src;
    logic [7:0] ctl_res;
    logic [1:0] hold_r;
    logic trace_r;
    logic [7:0] ctl_rd_r;
    logic [CRS_MAC_KEEP-1:0] mac_r;
    logic ctl_ext_hit;

    // stack steps take the single write port ahead of an ordinary write
    always_comb begin
        sp_step_val = SP_STEP_DOWN ? sp_r - (SP_STEP_LONG ? 32'h4 : 32'h2)
                                   : sp_r + (SP_STEP_LONG ? 32'h4 : 32'h2);
        mem_wr = GPR_WR;
        if (SP_STEP_EN) begin
            mem_wr.en = 1'b1;
            mem_wr.idx = CRS_SP_INDEX;
            mem_wr.part = CRS_PART_LONG;
            mem_wr.data = sp_step_val;
        end
    end

    crs_gpr_mem #(
        .DEPTH(CRS_GPR_COUNT)
    ) u_gpr (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CE),
        .wr(mem_wr),
        .rd_idx(GPR_RD_IDX),
        .rd_part(GPR_RD_PART),
        .rd_data(GPR_RD_DATA)
    );

    // shadow of register seven so the stack pointer is always visible
    assign sp_lanes = crs_lanes(mem_wr.part);
    for (genvar g = 0; g < 4; g++) begin : g_spmask
        assign sp_lane_mask[g*8 +: 8] = {8{sp_lanes[g]}};
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sp_r <= 32'h00000000;
        end else if (CE && mem_wr.en && mem_wr.idx == CRS_SP_INDEX) begin
            sp_r <= (sp_r & ~sp_lane_mask)
                  | (crs_place(mem_wr.data, mem_wr.part) & sp_lane_mask);
        end
    end
    assign STACK_PTR = sp_r;

    // fetch pointer; a load beats an advance
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            pc_r <= CRS_PC_RESET[ADDR_W-1:0];
        end else if (CE) begin
            if (PC_LOAD_EN) begin
                pc_r <= PC_LOAD_VAL;
            end else if (PC_ADV) begin
                pc_r <= pc_r + CRS_INSTR_BYTES[ADDR_W-1:0];
            end
        end
    end
    assign NEXT_FETCH_PTR = pc_r;
    assign FETCH_ADDR = {pc_r[ADDR_W-1:1], 1'b0};

    // shared logical unit of the control instructions
    always_comb begin
        ctl_src = CTL_REQ.to_ext ? exr_r : ccr_r;
        case (CTL_REQ.op)
            AND_CTL_INSTR: ctl_res = ctl_src & CTL_REQ.data;
            OR_CTL_INSTR: ctl_res = ctl_src | CTL_REQ.data;
            XOR_CTL_INSTR: ctl_res = ctl_src ^ CTL_REQ.data;
            default: ctl_res = CTL_REQ.data;
        endcase
    end
    assign ctl_ext_hit = CTL_REQ.en && CTL_REQ.to_ext && CTL_REQ.op != STORE_CTL_INSTR;

    always_comb begin
        exr_nxt = exr_r;
        if (ctl_ext_hit) begin
            exr_nxt = ctl_res | CRS_EXR_RSVD;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            exr_r <= CRS_EXR_RESET;
        end else if (CE) begin
            exr_r <= exr_nxt;
        end
    end
    assign EXTENDED_CTL_REG = exr_r;

    // condition codes: control op, then arithmetic, then direct flag writes
    always_comb begin
        logic [31:0] bx;
        logic [32:0] sum;
        logic ci;
        logic hc;
        logic cy;
        int top;
        hc = 1'b0;
        top = 31;
        bx = ALU_REQ.sub ? ~ALU_REQ.b : ALU_REQ.b;
        ci = ALU_REQ.sub ^ (ALU_REQ.use_carry & ccr_r[CRS_C_BIT]);
        sum = {1'b0, ALU_REQ.a} + {1'b0, bx} + {32'h00000000, ci};
        case (ALU_REQ.width)
            CRS_W8: begin
                top = 7;
                hc = carry_at(ALU_REQ.a, bx, ci, CRS_H_POS_B);
            end
            CRS_W16: begin
                top = 15;
                hc = carry_at(ALU_REQ.a, bx, ci, CRS_H_POS_W);
            end
            default: begin
                top = 31;
                hc = carry_at(ALU_REQ.a, bx, ci, CRS_H_POS_L);
            end
        endcase
        cy = carry_at(ALU_REQ.a, bx, ci, top);
        ccr_nxt = ccr_r;
        if (CTL_REQ.en && !CTL_REQ.to_ext && CTL_REQ.op != STORE_CTL_INSTR) begin
            ccr_nxt = ctl_res;
        end else if (ALU_REQ.en) begin
            ccr_nxt[CRS_H_BIT] = hc ^ ALU_REQ.sub;
            ccr_nxt[CRS_N_BIT] = sum[top];
            ccr_nxt[CRS_Z_BIT] = ({1'b0, sum[31:0]} & ((33'h000000002 << top) - 33'h000000001))
                                 == 33'h000000000;
            ccr_nxt[CRS_V_BIT] = (ALU_REQ.a[top] == bx[top]) && (sum[top] != ALU_REQ.a[top]);
            ccr_nxt[CRS_C_BIT] = cy ^ ALU_REQ.sub;
        end else if (FLAG_WR.en) begin
            ccr_nxt[5:0] = (ccr_r[5:0] & ~FLAG_WR.mask) | (FLAG_WR.val & FLAG_WR.mask);
        end
        // exception start wins over any clear in the same cycle
        if (EXC_START) begin
            ccr_nxt[CRS_IMASK_BIT] = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ccr_r <= CRS_CCR_RESET;
        end else if (CE) begin
            ccr_r <= ccr_nxt;
        end
    end
    assign COND_CODE_REG = ccr_r;
    assign BRANCH_TAKEN = cond_true(BRANCH_COND, ccr_r);

    // store returns the register as it stands, reserved bits included
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ctl_rd_r <= 8'h00;
        end else if (CE && CTL_REQ.en && CTL_REQ.op == STORE_CTL_INSTR) begin
            ctl_rd_r <= CTL_REQ.to_ext ? (exr_r | CRS_EXR_RSVD) : ccr_r;
        end
    end
    assign CTL_RD_DATA = ctl_rd_r;

    // hold-off counts states, so it stops with the clock enable
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            hold_r <= 2'h0;
        end else if (CE) begin
            if (ctl_ext_hit) begin
                hold_r <= CRS_HOLD_STATES;
            end else if (hold_r != 2'h0) begin
                hold_r <= hold_r - 2'h1;
            end
        end
    end
    assign INT_HOLD_OFF = hold_r != 2'h0;
    assign NMI_ACCEPT = NMI_REQ && !INT_HOLD_OFF;
    // user bit deliberately plays no part here
    assign IRQ_ACCEPT = IRQ_REQ && !NMI_REQ && !INT_HOLD_OFF && !ccr_r[CRS_IMASK_BIT]
                        && IRQ_LEVEL > exr_r[2:0];

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            trace_r <= 1'b0;
        end else if (CE) begin
            trace_r <= INSTR_DONE && exr_r[CRS_TRACE_BIT];
        end
    end
    assign TRACE_REQ = trace_r;

    // only 42 bits stored: upper high word bits are always sign copies
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            mac_r <= '0;
        end else if (CE) begin
            if (MAC_CLR) begin
                mac_r <= '0;
            end else if (MAC_WR_EN) begin
                mac_r <= MAC_WR_VAL[CRS_MAC_KEEP-1:0];
            end
        end
    end
    assign MULT_ACCUM_REG = {{(64-CRS_MAC_KEEP){mac_r[CRS_MAC_KEEP-1]}}, mac_r};

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    sequence s_ext_op;
        CE && ctl_ext_hit;
    endsequence
    sequence s_hold_count;
        hold_r == 2'h3 ##1 (!CE || ctl_ext_hit || hold_r == 2'h2 || hold_r == 2'h3);
    endsequence

    chk_hold_off_len: assert property (s_ext_op |=> s_hold_count)
        else $error("hold-off not loaded with three states");
    chk_store_no_hold: assert property (CE && CTL_REQ.en && CTL_REQ.op == STORE_CTL_INSTR
        && hold_r == 2'h0 |=> hold_r == 2'h0)
        else $error("store started a hold-off");
    chk_trace_pulse: assert property (CE && INSTR_DONE && exr_r[7] |=> TRACE_REQ)
        else $error("trace request missing");
    chk_exr_rsvd_ones: assert property ((exr_r & CRS_EXR_RSVD) == CRS_EXR_RSVD)
        else $error("reserved extended control bits not one");
    chk_imask_blocks: assert property (ccr_r[7] |-> !IRQ_ACCEPT)
        else $error("maskable interrupt passed the mask");
    chk_nmi_ungated: assert property (NMI_REQ && ccr_r[7] && hold_r == 2'h0
        |-> NMI_ACCEPT)
        else $error("non-maskable interrupt refused");
    chk_exc_sets_mask: assert property (CE && EXC_START |=> COND_CODE_REG[7])
        else $error("exception start left mask clear");
    chk_pc_advance: assert property (CE && PC_ADV && !PC_LOAD_EN
        |=> pc_r == $past(pc_r) + CRS_INSTR_BYTES[ADDR_W-1:0])
        else $error("fetch pointer did not advance by one word");
    chk_sp_step: assert property (CE && SP_STEP_EN && SP_STEP_DOWN && SP_STEP_LONG
        |=> STACK_PTR == $past(sp_r) - 32'h4)
        else $error("stack pointer push step wrong");
    chk_mac_sign_ext: assert property (MULT_ACCUM_REG[63:41] == {23{MULT_ACCUM_REG[41]}})
        else $error("mac high part not sign extended");
endmodule // cpu_register_set

// ---- include/crs_pkg.sv ----
// shared constants, types and decode functions of the cpu register set
package crs_pkg;
    localparam int CRS_GPR_COUNT = 8;
    localparam logic [2:0] CRS_SP_INDEX = 3'h7;
    localparam int CRS_ADDR_W = 24;
    localparam logic [23:0] CRS_PC_RESET = 24'h000000;
    localparam logic [23:0] CRS_INSTR_BYTES = 24'h000002;
    localparam int CRS_TRACE_BIT = 7;
    localparam logic [7:0] CRS_EXR_RSVD = 8'h78;
    localparam logic [7:0] CRS_EXR_RESET = 8'h7f;
    localparam int CRS_IMASK_BIT = 7;
    localparam int CRS_USER_BIT = 6;
    localparam int CRS_H_BIT = 5;
    localparam int CRS_N_BIT = 3;
    localparam int CRS_Z_BIT = 2;
    localparam int CRS_V_BIT = 1;
    localparam int CRS_C_BIT = 0;
    localparam logic [7:0] CRS_CCR_RESET = 8'h80;
    localparam logic [1:0] CRS_HOLD_STATES = 2'h3;
    localparam int CRS_MAC_KEEP = 42;
    localparam int CRS_H_POS_B = 3;
    localparam int CRS_H_POS_W = 11;
    localparam int CRS_H_POS_L = 27;

    typedef enum logic [2:0] {
        CRS_PART_LONG, CRS_PART_EXT, CRS_PART_WORD, CRS_PART_HIGH, CRS_PART_LOW
    } crs_part_type;
    typedef enum logic [1:0] {CRS_W8, CRS_W16, CRS_W32} crs_width_type;
    typedef enum logic [2:0] {
        LOAD_CTL_INSTR, STORE_CTL_INSTR, AND_CTL_INSTR, OR_CTL_INSTR, XOR_CTL_INSTR
    } crs_ctl_op_type;

    typedef struct packed {
        logic en;
        logic [2:0] idx;
        crs_part_type part;
        logic [31:0] data;
    } crs_gpr_req_type;
    typedef struct packed {
        logic en;
        logic to_ext;
        crs_ctl_op_type op;
        logic [7:0] data;
    } crs_ctl_req_type;
    typedef struct packed {
        logic en;
        crs_width_type width;
        logic sub;
        logic use_carry;
        logic [31:0] a;
        logic [31:0] b;
    } crs_alu_req_type;
    typedef struct packed {
        logic en;
        logic [5:0] mask;
        logic [5:0] val;
    } crs_flag_req_type;

    // byte lanes touched by an access to one part of a general register
    function automatic logic [3:0] crs_lanes(input crs_part_type p);
        case (p)
            CRS_PART_LONG: crs_lanes = 4'hf;
            CRS_PART_EXT: crs_lanes = 4'hc;
            CRS_PART_WORD: crs_lanes = 4'h3;
            CRS_PART_HIGH: crs_lanes = 4'h2;
            default: crs_lanes = 4'h1;
        endcase
    endfunction

    // move low-aligned write data up to the lanes of its part
    function automatic logic [31:0] crs_place(input logic [31:0] d, input crs_part_type p);
        case (p)
            CRS_PART_EXT: crs_place = {d[15:0], 16'h0000};
            CRS_PART_HIGH: crs_place = {16'h0000, d[7:0], 8'h00};
            default: crs_place = d;
        endcase
    endfunction
endpackage

// ---- hw/crs_gpr_mem.sv ----
// general register storage with part writes and registered part reads
`timescale 1ns/1ps
module crs_gpr_mem #(
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire crs_pkg::crs_gpr_req_type wr,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    input wire crs_pkg::crs_part_type rd_part,
    output logic [31:0] rd_data
);
    import crs_pkg::*;
    logic [3:0] wr_lanes;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    assign wr_lanes = crs_lanes(wr.part);
    assign wr_word = crs_place(wr.data, wr.part);

    // one array per byte lane so that each array has a single writing process
    // lanes outside the part keep their bits; no reset, registers start undefined
    for (genvar g = 0; g < 4; g++) begin : g_lane
        logic [7:0] lane_mem [DEPTH];
        always_ff @(posedge clk) begin
            if (ce && wr.en && wr_lanes[g]) begin
                lane_mem[wr.idx[$clog2(DEPTH)-1:0]] <= wr_word[g*8 +: 8];
            end
        end
        assign rd_word[g*8 +: 8] = lane_mem[rd_idx];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= 32'h00000000;
        end else if (ce) begin
            case (rd_part)
                CRS_PART_LONG: rd_data <= rd_word;
                CRS_PART_EXT: rd_data <= {16'h0000, rd_word[31:16]};
                CRS_PART_WORD: rd_data <= {16'h0000, rd_word[15:0]};
                CRS_PART_HIGH: rd_data <= {24'h000000, rd_word[15:8]};
                default: rd_data <= {24'h000000, rd_word[7:0]};
            endcase
        end
    end
endmodule // crs_gpr_mem

// ---- verification/crs_exec_model.sv ----
// execution-side model: exception entry pushes and a return pops the stack pointer
`timescale 1ns/1ps
module crs_exec_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic ret,
    output logic exc_start,
    output logic sp_en,
    output logic sp_down,
    output logic sp_long
);
    logic go_r;
    logic ret_r;
    // sample on the rising edge, drive on the falling one so the core sees settled levels
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            go_r <= 1'b0;
            ret_r <= 1'b0;
        end else begin
            go_r <= go;
            ret_r <= ret;
        end
    end
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            exc_start <= 1'b0;
            sp_en <= 1'b0;
            sp_down <= 1'b0;
            sp_long <= 1'b0;
        end else begin
            exc_start <= go_r;
            sp_en <= go_r | ret_r;
            // direction left high when idle: the core must ignore it without sp_en
            sp_down <= go_r | ~ret_r;
            sp_long <= go_r | ret_r;
        end
    end
endmodule // crs_exec_model

// ---- verification/cpu_register_set_tb.sv ----
// self-checking bench for the cpu register set
`timescale 1ns/1ps
module cpu_register_set_tb;
    import crs_pkg::*;
    logic clk = 0, rst = 1, ce = 1, go = 0, ret = 0;
    crs_gpr_req_type gwr = '0;
    logic [2:0] ridx = 0;
    crs_part_type rpart = CRS_PART_LONG;
    logic [31:0] rdata, sp;
    logic pc_ld = 0, pc_adv = 0;
    logic [23:0] pc_val = 0, pc, fa;
    crs_ctl_req_type ctl = '0;
    logic [7:0] crd, extended_control, condition_code;
    crs_alu_req_type alu = '0;
    crs_flag_req_type fw = '0;
    logic exc, sp_en, sp_dn, sp_lg, trace, nmi_ok, irq_ok, hold, taken;
    logic idone = 0, nmi = 0, irq = 0, mclr = 0, mwe = 0;
    logic [2:0] lvl = 0;
    logic [3:0] bc = 0;
    logic [63:0] mval = 0, mac;
    int n_fail = 0, tests_run = 0, cyc = 0;
    crs_exec_model i_crs_exec_model (.clk(clk), .rst(rst), .go(go), .ret(ret),
        .exc_start(exc), .sp_en(sp_en), .sp_down(sp_dn), .sp_long(sp_lg));
    cpu_register_set i_cpu_register_set (.SYS_CLK(clk), .RESET(rst), .CE(ce), .GPR_WR(gwr),
        .GPR_RD_IDX(ridx), .GPR_RD_PART(rpart), .GPR_RD_DATA(rdata), .SP_STEP_EN(sp_en),
        .SP_STEP_DOWN(sp_dn), .SP_STEP_LONG(sp_lg), .STACK_PTR(sp), .PC_LOAD_EN(pc_ld),
        .PC_LOAD_VAL(pc_val), .PC_ADV(pc_adv), .NEXT_FETCH_PTR(pc), .FETCH_ADDR(fa),
        .CTL_REQ(ctl), .CTL_RD_DATA(crd), .EXTENDED_CTL_REG(extended_control), .COND_CODE_REG(condition_code),
        .ALU_REQ(alu), .FLAG_WR(fw), .EXC_START(exc), .INSTR_DONE(idone), .TRACE_REQ(trace),
        .NMI_REQ(nmi), .IRQ_REQ(irq), .IRQ_LEVEL(lvl), .NMI_ACCEPT(nmi_ok),
        .IRQ_ACCEPT(irq_ok), .INT_HOLD_OFF(hold), .BRANCH_COND(bc), .BRANCH_TAKEN(taken),
        .MAC_CLR(mclr), .MAC_WR_EN(mwe), .MAC_WR_VAL(mval), .MULT_ACCUM_REG(mac));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // the run is a few hundred cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(negedge clk);
    endtask
    task automatic gw(input logic [2:0] i, input crs_part_type p, input logic [31:0] d);
        gwr = '{1'b1, i, p, d};
        tick();
        gwr.en = 1'b0;
        tick();
    endtask
    task automatic rc(input logic [2:0] i, input crs_part_type p, input logic [31:0] e);
        ridx = i;
        rpart = p;
        tick();
        chk(rdata, e);
    endtask
    task automatic cop(input logic te, input crs_ctl_op_type o, input logic [7:0] d);
        ctl = '{1'b1, te, o, d};
        tick();
        ctl.en = 1'b0;
    endtask
    task automatic t_reset;
        rst = 1'b1;
        repeat (20) tick();
        rst = 1'b0;
        tick();
        chk(extended_control, 8'h7f);
        chk(extended_control[6:3], 4'hf);
        chk(extended_control[2:0], 3'h7);
        chk(condition_code[7], 1'b1);
        chk(pc, 24'h0);
        chk({trace, hold}, 2'b00);
    endtask
    task automatic t_gpr;
        for (int i = 0; i < 8; i++) begin
            gw(i[2:0], CRS_PART_LONG, 32'h11223300 | i);
            gw(i[2:0], CRS_PART_HIGH, 32'hab);
            gw(i[2:0], CRS_PART_EXT, 32'h5566);
            rc(i[2:0], CRS_PART_LONG, 32'h5566ab00 | i);
            gw(i[2:0], CRS_PART_LOW, 32'hc0 | i);
            rc(i[2:0], CRS_PART_WORD, 32'habc0 | i);
            rc(i[2:0], CRS_PART_EXT, 32'h5566);
            rc(i[2:0], CRS_PART_HIGH, 32'hab);
            gw(i[2:0], CRS_PART_WORD, 32'h1234);
            rc(i[2:0], CRS_PART_LONG, 32'h55661234);
            rc(i[2:0], CRS_PART_LOW, 32'h34);
        end
        chk(sp, 32'h55661234);
    endtask
    task automatic t_stack;
        gw(3'h7, CRS_PART_LONG, 32'h1000);
        cop(1'b0, LOAD_CTL_INSTR, 8'h00);
        chk(condition_code[7], 1'b0);
        go = 1'b1;
        tick();
        go = 1'b0;
        tick();
        chk(sp, 32'hffc);
        chk(condition_code[7], 1'b1);
        ret = 1'b1;
        tick();
        ret = 1'b0;
        tick();
        rc(3'h7, CRS_PART_LONG, 32'h1000);
    endtask
    task automatic t_pc;
        pc_val = 24'h123457;
        pc_ld = 1'b1;
        tick();
        pc_ld = 1'b0;
        chk({pc, fa}, {24'h123457, 24'h123456});
        pc_adv = 1'b1;
        tick();
        pc_adv = 1'b0;
        chk({pc, fa}, {24'h123459, 24'h123458});
        pc_val = 24'hffffff;
        pc_ld = 1'b1;
        tick();
        pc_ld = 1'b0;
        chk(fa, 24'hfffffe);
        ce = 1'b0;
        pc_adv = 1'b1;
        tick();
        chk(pc, 24'hffffff);
        ce = 1'b1;
        pc_adv = 1'b0;
    endtask
    task automatic t_exr;
        crs_ctl_op_type ops[4];
        logic [7:0] dat[4];
        logic [7:0] exp[4];
        ops = '{LOAD_CTL_INSTR, OR_CTL_INSTR, AND_CTL_INSTR, XOR_CTL_INSTR};
        dat = '{8'h00, 8'h05, 8'h06, 8'h03};
        exp = '{8'h78, 8'h7d, 8'h7c, 8'h7f};
        nmi = 1'b1;
        for (int k = 0; k < 4; k++) begin
            cop(1'b1, ops[k], dat[k]);
            chk(extended_control, exp[k]);
            for (int j = 0; j < 3; j++) begin
                chk({hold, nmi_ok}, 2'b10);
                tick();
            end
            chk({hold, nmi_ok}, 2'b01);
        end
        cop(1'b1, STORE_CTL_INSTR, 8'h00);
        chk({crd, extended_control, hold}, {8'h7f, 8'h7f, 1'b0});
        tick();
        nmi = 1'b0;
        cop(1'b1, LOAD_CTL_INSTR, 8'h80);
        chk(extended_control, 8'hf8);
        idone = 1'b1;
        tick();
        idone = 1'b0;
        chk(trace, 1'b1);
        tick();
        chk(trace, 1'b0);
        cop(1'b1, LOAD_CTL_INSTR, 8'h00);
        idone = 1'b1;
        tick();
        idone = 1'b0;
        chk(trace, 1'b0);
        repeat (3) tick();
    endtask
    task automatic t_irq;
        irq = 1'b1;
        lvl = 3'h3;
        cop(1'b0, LOAD_CTL_INSTR, 8'h00);
        chk(irq_ok, 1'b1);
        tick();
        cop(1'b0, LOAD_CTL_INSTR, 8'h40);
        chk({condition_code[6], irq_ok}, 2'b11);
        lvl = 3'h0;
        tick();
        chk(irq_ok, 1'b0);
        lvl = 3'h3;
        cop(1'b0, LOAD_CTL_INSTR, 8'h80);
        chk(irq_ok, 1'b0);
        nmi = 1'b1;
        tick();
        chk(nmi_ok, 1'b1);
        nmi = 1'b0;
        irq = 1'b0;
    endtask
    task automatic al(input crs_width_type w, input logic s, input logic [31:0] a,
        input logic [31:0] b, input logic [7:0] e);
        alu = '{1'b1, w, s, 1'b0, a, b};
        tick();
        alu.en = 1'b0;
        chk(condition_code & 8'h2f, e);
        tick();
    endtask
    task automatic br(input logic [3:0] c, input logic e);
        bc = c;
        tick();
        chk(taken, e);
    endtask
    task automatic t_flags;
        al(CRS_W8, 1'b0, 32'h0f, 32'h01, 8'h20);
        al(CRS_W16, 1'b0, 32'h0fff, 32'h01, 8'h20);
        al(CRS_W32, 1'b0, 32'h0fffffff, 32'h01, 8'h20);
        al(CRS_W8, 1'b1, 32'h00, 32'h01, 8'h29);
        al(CRS_W8, 1'b0, 32'hff, 32'h01, 8'h25);
        br(4'h7, 1'b1);
        br(4'h6, 1'b0);
        br(4'h5, 1'b1);
        br(4'h4, 1'b0);
        fw = '{1'b1, 6'h01, 6'h00};
        tick();
        fw.en = 1'b0;
        chk(condition_code[0], 1'b0);
        al(CRS_W8, 1'b0, 32'h7f, 32'h01, 8'h2a);
        br(4'ha, 1'b0);
        br(4'hb, 1'b1);
        br(4'h8, 1'b0);
        br(4'h9, 1'b1);
        br(4'hc, 1'b1);
        br(4'hd, 1'b0);
    endtask
    task automatic t_mac;
        mval = 64'h0000_0200_0000_0001;
        mwe = 1'b1;
        tick();
        mwe = 1'b0;
        chk(mac, 64'hffff_fe00_0000_0001);
        mclr = 1'b1;
        tick();
        mclr = 1'b0;
        chk(mac, 64'h0);
    endtask
    initial begin
        t_reset();
        t_gpr();
        t_stack();
        t_pc();
        t_exr();
        t_irq();
        t_flags();
        t_mac();
        t_reset();
        give_verdict();
    end
endmodule // cpu_register_set_tb
